// File: bus_master_end.sv
// Master end: address and data tenure sequencing for one processor.
// Assumes a central arbiter and slaves on the same bus clock, and a
// memory subsystem that holds a request stable until it is taken.
//
// Notes on behaviour
// - Each access: address tenure, then data tenure.
// - Block-zero, sync, barrier, clean flush: address only.
// - Address and data tenures advance independently.
// - Single beat 64 bits; burst terminates each beat.
// - Burst tenure ends after its final beat.
// - Busy lines are driven only, never sampled.
// - Request held until qualified grant arrives.
// - Grant qualified by retry, start and busy.
// - Parked grant taken without any request.
// - Address busy asserted exactly while address master.
// - Data grant needs no retry and pending work.
// - No data retry exists; beats are final.
// - Write hint takes writes first, reads if none.
// - Qualified data grant always taken, busy asserted.
// - At most six address tenures await data.
// - Data tenures follow address order unless hinted.
// - Arbiter tracks its own address busy copy.
// - Arbiter sets pipeline depth through grant timing.
// - Cancelled request never asserts busy nor uses bus.
// - Abandoned request still held one cycle minimum.
// - System acknowledges or retries every address transfer.
// - Everything sampled and driven on rising edge.
// - Address busy drops one cycle after acknowledge.
module bus_master_end #(
    parameter int MAX_OUT = split_bus_pkg::MAX_PENDING,
    parameter int CW      = $clog2(MAX_OUT + 1)
) (
    // Clock, reset, enable
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire logic                     ce,
    // Bus
    tenure_bus_if.master                  bus,
    // Request from the memory subsystem
    input  wire logic                     reqValid,
    input  wire split_bus_pkg::txn_kind_t reqKind,
    input  wire logic                     reqBurst,
    output logic                          reqReady,
    // Tenure progress
    output logic                          addrRetried,
    output logic                          dataStart,
    output logic                          dataBeat,
    output logic                          dataDone,
    output logic                          dataIsWrite,
    output logic                          dataIsBurst,
    output logic      [CW-1:0]            pendingCount
);
    typedef enum {
        A_IDLE,
        A_REQ,
        A_TENURE,
        A_WINDOW
    } addr_state_t;

    typedef enum {
        D_IDLE,
        D_XFER
    } data_state_t;

    addr_state_t aState_q;
    addr_state_t aState_d;
    data_state_t dState_q;
    logic        retryPrev_q;
    logic        start_q;
    logic        kindWrite_q;
    logic        kindOnly_q;
    logic        burst_q;
    logic [2:0]  beatsLeft_q;
    logic        dataWrite_q;
    logic        dataBurst_q;

    logic          needBus;
    logic          qualGrant;
    logic          commit;
    logic          qualData;
    logic          hint;
    logic [CW-1:0] count;
    logic          headWrite;
    logic          headBurst;
    logic          writeFound;
    logic [CW-1:0] writeIdx;
    logic          writeBurst;
    logic [CW-1:0] takeIdx;
    logic          takeWrite;
    logic          takeBurst;

    // ------------------------------------------------------------------
    // Address arbitration
    // ------------------------------------------------------------------
    // A full queue holds off the next address tenure until a data
    // grant frees a slot.
    assign needBus = reqValid && (count < CW'(MAX_OUT));

    // Own busy copy is the tenure state; bus busy is never read.
    assign qualGrant = !bus.addressGrantN && bus.addressRetryN
                       && retryPrev_q && bus.transferStartN
                       && (aState_q != A_TENURE);

    always_comb begin
        aState_d = aState_q;
        case (aState_q)
            A_IDLE: begin
                if (needBus && qualGrant) begin
                    aState_d = A_TENURE;
                end else if (needBus && bus.addressGrantN) begin
                    aState_d = A_REQ;
                end
            end
            A_REQ: begin
                // Request already stood a full cycle before abandon.
                if (!needBus) begin
                    aState_d = A_IDLE;
                end else if (qualGrant) begin
                    aState_d = A_TENURE;
                end
            end
            A_TENURE: begin
                if (!bus.addressAcknowledgeN) begin
                    aState_d = A_WINDOW;
                end
            end
            A_WINDOW: begin
                aState_d = A_IDLE;
            end
            default: begin
                aState_d = A_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aState_q <= A_IDLE;
        end else if (ce) begin
            aState_q <= aState_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            retryPrev_q <= 1'b1;
        end else if (ce) begin
            retryPrev_q <= bus.addressRetryN;
        end
    end

    // Attributes are frozen at grant so the user may not disturb them.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            start_q     <= 1'b0;
            kindWrite_q <= 1'b0;
            kindOnly_q  <= 1'b0;
            burst_q     <= 1'b0;
        end else if (ce) begin
            start_q <= 1'b0;
            if (aState_q != A_TENURE && aState_d == A_TENURE) begin
                start_q     <= 1'b1;
                kindWrite_q <= reqKind == split_bus_pkg::KIND_WRITE;
                kindOnly_q  <= reqKind == split_bus_pkg::KIND_ADDR_ONLY;
                burst_q     <= reqBurst
                               && reqKind != split_bus_pkg::KIND_ADDR_ONLY;
            end
        end
    end

    // ------------------------------------------------------------------
    // Address termination and commit
    // ------------------------------------------------------------------
    // A tenure counts only once its retry window has passed clean.
    assign commit      = (aState_q == A_WINDOW) && bus.addressRetryN;
    assign reqReady    = commit && ce;
    assign addrRetried = (aState_q == A_WINDOW) && !bus.addressRetryN
                         && ce;

    // ------------------------------------------------------------------
    // Pending data tenures
    // ------------------------------------------------------------------
    tenure_queue #(
        .DEPTH (MAX_OUT),
        .CW    (CW)
    ) u_queue (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .ce         (ce),
        .pushValid  (commit && !kindOnly_q),
        .pushWrite  (kindWrite_q),
        .pushBurst  (burst_q),
        .popValid   (qualData),
        .popIdx     (takeIdx),
        .count      (count),
        .headWrite  (headWrite),
        .headBurst  (headBurst),
        .writeFound (writeFound),
        .writeIdx   (writeIdx),
        .writeBurst (writeBurst)
    );

    assign pendingCount = count;

    // ------------------------------------------------------------------
    // Data arbitration
    // ------------------------------------------------------------------
    assign hint = !bus.writeOnlyDataHintN;

    // Hint picks the oldest write; with no write the head read goes.
    assign takeIdx   = (hint && writeFound) ? writeIdx : '0;
    assign takeWrite = (hint && writeFound) ? 1'b1 : headWrite;
    assign takeBurst = (hint && writeFound) ? writeBurst : headBurst;

    assign qualData = ce && !bus.dataGrantN && bus.addressRetryN
                      && count != '0 && dState_q == D_IDLE;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dState_q    <= D_IDLE;
            beatsLeft_q <= 3'h0;
            dataWrite_q <= 1'b0;
            dataBurst_q <= 1'b0;
        end else if (ce) begin
            case (dState_q)
                D_IDLE: begin
                    if (qualData) begin
                        dState_q    <= D_XFER;
                        dataWrite_q <= takeWrite;
                        dataBurst_q <= takeBurst;
                        beatsLeft_q <= takeBurst
                                       ? split_bus_pkg::BEATS_BURST
                                       : split_bus_pkg::BEATS_SINGLE;
                    end
                end
                D_XFER: begin
                    // Each termination is final; nothing is replayed.
                    if (!bus.dataTerminateN) begin
                        beatsLeft_q <= beatsLeft_q - 3'h1;
                        if (beatsLeft_q == 3'h1) begin
                            dState_q <= D_IDLE;
                        end
                    end
                end
                default: begin
                    dState_q <= D_IDLE;
                end
            endcase
        end
    end

    assign dataStart = qualData;
    assign dataBeat  = ce && dState_q == D_XFER && !bus.dataTerminateN;
    assign dataDone  = dataBeat && beatsLeft_q == 3'h1;
    assign dataIsWrite = dataWrite_q;
    assign dataIsBurst = dataBurst_q;

    // ------------------------------------------------------------------
    // Bus drive
    // ------------------------------------------------------------------
    assign bus.busRequestN    = !(aState_q == A_REQ);
    assign bus.transferStartN = !start_q;
    assign bus.attrWrite      = kindWrite_q;
    assign bus.attrBurst      = burst_q;
    assign bus.attrAddrOnly   = kindOnly_q;

    // Busy is pulled low only while master, released otherwise.
    assign bus.addrBusyOutN = 1'b0;
    assign bus.addrBusyOeN  = !(aState_q == A_TENURE);
    assign bus.dataBusyOutN = 1'b0;
    assign bus.dataBusyOeN  = !(dState_q == D_XFER);

endmodule : bus_master_end

// File: central_arbiter_end.sv
// Central arbiter end: grants, acknowledges and terminates tenures.
// Assumes a single master on the bus and a slave side that paces
// acknowledges, retries and beats through the user ports.
module central_arbiter_end #(
    parameter int PIPE_DEPTH = split_bus_pkg::MAX_PENDING,
    parameter int CW         = $clog2(PIPE_DEPTH + 1)
) (
    // Clock, reset, enable
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire logic          ce,
    // Bus
    tenure_bus_if.arbiter      bus,
    // Policy and slave pacing
    input  wire logic          parkEnable,
    input  wire logic          ackReady,
    input  wire logic          retryReq,
    input  wire logic          dataGrantEnable,
    input  wire logic          writeOnlyHint,
    input  wire logic          beatReady,
    // Status
    output logic               addrBusySeen,
    output logic      [CW-1:0] pendingCount
);
    logic          busyRecon_q;
    logic          window_q;
    logic          retry_q;
    logic          only_q;
    logic          granted_q;
    logic [CW-1:0] pend_q;
    logic          ack;
    logic          dGrant;
    logic          commit;

    // ------------------------------------------------------------------
    // Reconstructed address busy: start to acknowledge
    // ------------------------------------------------------------------
    assign ack = busyRecon_q && ackReady;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busyRecon_q <= 1'b0;
            window_q    <= 1'b0;
            retry_q     <= 1'b0;
            only_q      <= 1'b0;
        end else if (ce) begin
            window_q <= ack;
            if (!bus.transferStartN) begin
                busyRecon_q <= 1'b1;
                only_q      <= bus.attrAddrOnly;
            end else if (ack) begin
                busyRecon_q <= 1'b0;
            end
            if (ack) begin
                retry_q <= retryReq;
            end
        end
    end

    // ------------------------------------------------------------------
    // Address grant, acknowledge and retry
    // ------------------------------------------------------------------
    // Grant withheld while busy, in the retry window, or pipeline full.
    assign bus.addressGrantN = !(!busyRecon_q && bus.transferStartN
                                 && !window_q
                                 && pend_q < CW'(PIPE_DEPTH)
                                 && (parkEnable || !bus.busRequestN));
    assign bus.addressAcknowledgeN = !ack;
    assign bus.addressRetryN       = !(window_q && retry_q);

    // ------------------------------------------------------------------
    // Data grant and beat termination
    // ------------------------------------------------------------------
    assign commit = window_q && !retry_q && !only_q;
    assign dGrant = ce && dataGrantEnable && pend_q != '0
                    && bus.dataBusyN && !granted_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pend_q    <= '0;
            granted_q <= 1'b0;
        end else if (ce) begin
            granted_q <= dGrant;
            pend_q    <= pend_q + CW'(commit) - CW'(dGrant);
        end
    end

    assign bus.dataGrantN         = !dGrant;
    assign bus.writeOnlyDataHintN = !writeOnlyHint;
    // Terminations are final: no data retry path exists.
    assign bus.dataTerminateN     = !(beatReady && !bus.dataBusyN);

    assign addrBusySeen = busyRecon_q;
    assign pendingCount = pend_q;

endmodule : central_arbiter_end

// File: split_bus_assertions.sv
// Checker for the tenure bus between the master and arbiter ends.
// Assumes plain connections to the interface signals, one clock.
module split_bus_assertions (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bus wires
    input wire logic busRequestN,
    input wire logic addressGrantN,
    input wire logic transferStartN,
    input wire logic addressAcknowledgeN,
    input wire logic addressRetryN,
    input wire logic dataGrantN,
    input wire logic dataTerminateN,
    input wire logic addressBusyN,
    input wire logic dataBusyN
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    AST_RESET_QUIET: assert property (disable iff (1'b0)
        rst |=> busRequestN && addressBusyN && dataBusyN)
        else $error("bus not quiet after reset");
    AST_START_BUSY: assert property (
        !transferStartN |-> !addressBusyN)
        else $error("start without address busy");
    AST_QUAL_GRANT: assert property ($fell(addressBusyN) |->
        $past(!addressGrantN && transferStartN && addressRetryN)
        && $past(addressRetryN, 2))
        else $error("busy without qualified grant");
    AST_BUSY_WITH_START: assert property ($fell(addressBusyN) |->
        !transferStartN)
        else $error("address busy without start");
    AST_ACK_RELEASE: assert property (!addressAcknowledgeN |=>
        addressBusyN)
        else $error("busy held after ack");
    AST_BUSY_GAP: assert property (
        $rose(addressBusyN) |=> addressBusyN)
        else $error("busy gap too short");
    AST_ACK_IN_TENURE: assert property (!addressAcknowledgeN |->
        !addressBusyN)
        else $error("acknowledge outside address tenure");
    AST_RETRY_WINDOW: assert property (!addressRetryN |->
        $past(!addressAcknowledgeN))
        else $error("retry outside retry window");
    AST_DATA_TAKE: assert property (
        $fell(dataBusyN) |-> $past(!dataGrantN))
        else $error("data busy without data grant");
    AST_TERM_IN_TENURE: assert property (
        !dataTerminateN |-> !dataBusyN)
        else $error("term outside tenure");
    AST_DATA_END: assert property ($rose(dataBusyN) |->
        $past(!dataTerminateN))
        else $error("data end without term");

    cover property (!addressRetryN);
    cover property ($rose(dataBusyN));
    cover property (!busRequestN ##1 !addressGrantN);
endmodule : split_bus_assertions

// File: split_bus_pkg.sv
// Shared constants and types for the split-tenure bus arbitration pair.
// Assumes every bus signal is synchronous to sys_clk.
package split_bus_pkg;

    // ------------------------------------------------------------------
    // Transaction kinds
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        KIND_READ,
        KIND_WRITE,
        KIND_ADDR_ONLY
    } txn_kind_t;

    // ------------------------------------------------------------------
    // Sizes and counts
    // ------------------------------------------------------------------
    localparam int       MAX_PENDING  = 6;
    localparam int       BEAT_BITS    = 64;
    localparam int       LINE_BYTES   = 32;
    localparam logic [2:0] BEATS_SINGLE = 3'h1;
    localparam logic [2:0] BEATS_BURST  = 3'h4;

endpackage : split_bus_pkg

// File: split_bus_tenure_arbitration_test.sv
// Bench joining the master end to the arbiter end over the interface.
// Assumes a 50 MHz clock and a synchronous active-high reset.
module split_bus_tenure_arbitration_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic reqValid = 1'b0;
    logic reqBurst = 1'b0;
    split_bus_pkg::txn_kind_t reqKind = split_bus_pkg::KIND_READ;
    logic parkEnable = 1'b0, ackReady = 1'b1, retryReq = 1'b0;
    logic dataGrantEnable = 1'b0, writeOnlyHint = 1'b0, beatReady = 1'b1;
    logic reqReady, addrRetried, dataStart, dataBeat, dataDone;
    logic dataIsWrite, dataIsBurst, addrBusySeen;
    logic [2:0] pendM, pendA;
    logic ok, sr, st, fw, fb;
    int failures = 0;
    int nTests = 0;
    logic [7:0] beats;

    always #10 sys_clk = ~sys_clk;

    tenure_bus_if tenure_bus_if_inst (.sys_clk(sys_clk));
    bus_master_end bus_master_end_inst (.sys_clk(sys_clk), .rst(rst),
        .ce(1'b1), .bus(tenure_bus_if_inst.master), .reqValid(reqValid),
        .reqKind(reqKind), .reqBurst(reqBurst), .reqReady(reqReady),
        .addrRetried(addrRetried), .dataStart(dataStart),
        .dataBeat(dataBeat), .dataDone(dataDone), .dataIsWrite(dataIsWrite),
        .dataIsBurst(dataIsBurst), .pendingCount(pendM));
    central_arbiter_end central_arbiter_end_inst (.sys_clk(sys_clk),
        .rst(rst), .ce(1'b1), .bus(tenure_bus_if_inst.arbiter),
        .parkEnable(parkEnable), .ackReady(ackReady), .retryReq(retryReq),
        .dataGrantEnable(dataGrantEnable), .writeOnlyHint(writeOnlyHint),
        .beatReady(beatReady), .addrBusySeen(addrBusySeen),
        .pendingCount(pendA));
    split_bus_assertions split_bus_assertions_inst (.sys_clk(sys_clk),
        .rst(rst), .busRequestN(tenure_bus_if_inst.busRequestN),
        .addressGrantN(tenure_bus_if_inst.addressGrantN),
        .transferStartN(tenure_bus_if_inst.transferStartN),
        .addressAcknowledgeN(tenure_bus_if_inst.addressAcknowledgeN),
        .addressRetryN(tenure_bus_if_inst.addressRetryN),
        .dataGrantN(tenure_bus_if_inst.dataGrantN),
        .dataTerminateN(tenure_bus_if_inst.dataTerminateN),
        .addressBusyN(tenure_bus_if_inst.addressBusyN),
        .dataBusyN(tenure_bus_if_inst.dataBusyN));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        nTests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("comparisons=%0d mismatches=%0d", nTests, failures);
        if (failures == 0 && nTests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done

    // Request stays up on refusal so a later call picks it up again
    task automatic issue(input split_bus_pkg::txn_kind_t k, input logic b,
                         input int lim);
        ok = 1'b0;
        sr = 1'b0;
        st = 1'b0;
        @(posedge sys_clk);
        reqValid <= 1'b1;
        reqKind <= k;
        reqBurst <= b;
        repeat (lim) begin
            @(negedge sys_clk);
            if (tenure_bus_if_inst.busRequestN === 1'b0) sr = 1'b1;
            if (addrRetried === 1'b1) st = 1'b1;
            if (reqReady === 1'b1) begin
                ok = 1'b1;
                break;
            end
        end
        if (ok) @(posedge sys_clk) reqValid <= 1'b0;
    endtask : issue

    task automatic drain(input int n);
        beats = 8'h0;
        @(posedge sys_clk) dataGrantEnable <= 1'b1;
        repeat (300) begin
            @(negedge sys_clk);
            if (dataBeat === 1'b1 && beats == 0) begin
                fw = dataIsWrite;
                fb = dataIsBurst;
            end
            if (dataBeat === 1'b1) beats++;
            if (dataDone === 1'b1) n--;
            if (n == 0) break;
        end
        @(posedge sys_clk) dataGrantEnable <= 1'b0;
    endtask : drain

    task automatic t_parked;
        @(posedge sys_clk) parkEnable <= 1'b1;
        issue(split_bus_pkg::KIND_ADDR_ONLY, 1'b0, 50);
        check({ok, sr}, 8'h02);
        issue(split_bus_pkg::KIND_WRITE, 1'b0, 50);
        repeat (4) @(posedge sys_clk);
        check(pendM, 8'h01);
        drain(1);
        check(beats, 8'h01);
        @(posedge sys_clk) parkEnable <= 1'b0;
    endtask : t_parked

    task automatic t_burst_retry;
        issue(split_bus_pkg::KIND_READ, 1'b1, 50);
        check({ok, sr}, 8'h03);
        drain(1);
        check({beats[5:0], fb, fw}, 8'h12);
        @(posedge sys_clk) retryReq <= 1'b1;
        issue(split_bus_pkg::KIND_READ, 1'b0, 8);
        check({ok, st}, 8'h01);
        @(posedge sys_clk) retryReq <= 1'b0;
        issue(split_bus_pkg::KIND_READ, 1'b0, 50);
        check(ok, 8'h01);
        drain(1);
    endtask : t_burst_retry

    task automatic t_hint;
        issue(split_bus_pkg::KIND_READ, 1'b0, 50);
        issue(split_bus_pkg::KIND_WRITE, 1'b0, 50);
        repeat (4) @(posedge sys_clk);
        writeOnlyHint <= 1'b1;
        drain(1);
        check(fw, 8'h01);
        writeOnlyHint <= 1'b0;
        drain(1);
        check(fw, 8'h00);
    endtask : t_hint

    task automatic t_pipeline;
        for (int i = 0; i < 6; i++) begin
            issue(i == 0 ? split_bus_pkg::KIND_WRITE
                         : split_bus_pkg::KIND_READ, 1'b0, 50);
            check(ok, 8'h01);
        end
        repeat (4) @(posedge sys_clk);
        check({pendM, pendA}, 8'h36);
        issue(split_bus_pkg::KIND_READ, 1'b0, 30);
        check(ok, 8'h00);
        drain(1);
        check(fw, 8'h01);
        issue(split_bus_pkg::KIND_READ, 1'b0, 50);
        check(ok, 8'h01);
        drain(6);
        check(beats, 8'h06);
    endtask : t_pipeline

    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        test_done();
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        check({tenure_bus_if_inst.busRequestN,
               tenure_bus_if_inst.addressBusyN,
               tenure_bus_if_inst.dataBusyN, pendM, addrBusySeen,
               dataStart}, 8'hE0);
        t_parked();
        t_burst_retry();
        t_hint();
        t_pipeline();
        test_done();
    end
endmodule : split_bus_tenure_arbitration_test

// File: tenure_bus_if.sv
// Bus wires between the master end and the central arbiter end.
// Assumes both ends run on sys_clk; busy lines are open-drain with
// a pull-up, resolved here from each driver's output enable.
interface tenure_bus_if (
    input wire logic sys_clk
);
    // Address arbitration and termination
    logic busRequestN;
    logic addressGrantN;
    logic transferStartN;
    logic addressAcknowledgeN;
    logic addressRetryN;
    // Transfer attributes, valid with transferStartN
    logic attrWrite;
    logic attrBurst;
    logic attrAddrOnly;
    // Data arbitration and termination
    logic dataGrantN;
    logic writeOnlyDataHintN;
    logic dataTerminateN;
    // Open-drain busy lines: value, enable (low drives) and wire level
    logic addrBusyOutN;
    logic addrBusyOeN;
    logic dataBusyOutN;
    logic dataBusyOeN;
    logic addressBusyN;
    logic dataBusyN;

    // ------------------------------------------------------------------
    // Pull-up resolution
    // ------------------------------------------------------------------
    assign addressBusyN = addrBusyOeN ? 1'b1 : addrBusyOutN;
    assign dataBusyN    = dataBusyOeN ? 1'b1 : dataBusyOutN;

    modport master (
        input  sys_clk,
        input  addressGrantN,
        input  addressAcknowledgeN,
        input  addressRetryN,
        input  dataGrantN,
        input  writeOnlyDataHintN,
        input  dataTerminateN,
        output busRequestN,
        output transferStartN,
        output attrWrite,
        output attrBurst,
        output attrAddrOnly,
        output addrBusyOutN,
        output addrBusyOeN,
        output dataBusyOutN,
        output dataBusyOeN
    );

    modport arbiter (
        input  sys_clk,
        input  busRequestN,
        input  transferStartN,
        input  attrWrite,
        input  attrBurst,
        input  attrAddrOnly,
        input  addressBusyN,
        input  dataBusyN,
        output addressGrantN,
        output addressAcknowledgeN,
        output addressRetryN,
        output dataGrantN,
        output writeOnlyDataHintN,
        output dataTerminateN
    );
endinterface : tenure_bus_if

// File: tenure_queue.sv
// Queue of committed address tenures still waiting for a data grant.
// Assumes the owner never pushes into a full queue unless it pops in
// the same cycle, and pops only a valid index.
module tenure_queue #(
    parameter int DEPTH = split_bus_pkg::MAX_PENDING,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    // Clock, reset, enable
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire logic          ce,
    // Push side
    input  wire logic          pushValid,
    input  wire logic          pushWrite,
    input  wire logic          pushBurst,
    // Removal at any index
    input  wire logic          popValid,
    input  wire logic [CW-1:0] popIdx,
    // Status
    output logic      [CW-1:0] count,
    output logic               headWrite,
    output logic               headBurst,
    output logic               writeFound,
    output logic      [CW-1:0] writeIdx,
    output logic               writeBurst
);
    logic          entWrite [DEPTH];
    logic          entBurst [DEPTH];
    logic [CW-1:0] countQ;
    logic [CW-1:0] pushPos;

    assign count     = countQ;
    assign headWrite = entWrite[0];
    assign headBurst = entBurst[0];
    assign pushPos   = popValid ? countQ - CW'(1) : countQ;

    // ------------------------------------------------------------------
    // Entries: removal compacts the tail, keeping issue order
    // ------------------------------------------------------------------
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        logic nxtW;
        logic nxtB;
        if (i + 1 < DEPTH) begin : g_mid
            assign nxtW = entWrite[i + 1];
            assign nxtB = entBurst[i + 1];
        end else begin : g_end
            assign nxtW = 1'b0;
            assign nxtB = 1'b0;
        end
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                entWrite[i] <= 1'b0;
                entBurst[i] <= 1'b0;
            end else if (ce) begin
                if (pushValid && pushPos == CW'(i)) begin
                    entWrite[i] <= pushWrite;
                    entBurst[i] <= pushBurst;
                end else if (popValid && CW'(i) >= popIdx) begin
                    entWrite[i] <= nxtW;
                    entBurst[i] <= nxtB;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            countQ <= '0;
        end else if (ce) begin
            countQ <= countQ + CW'(pushValid) - CW'(popValid);
        end
    end

    // ------------------------------------------------------------------
    // Oldest pending write, for write-only reordering
    // ------------------------------------------------------------------
    always_comb begin
        writeFound = 1'b0;
        writeIdx   = '0;
        writeBurst = 1'b0;
        for (int i = DEPTH - 1; i >= 0; i--) begin
            if (CW'(i) < countQ && entWrite[i]) begin
                writeFound = 1'b1;
                writeIdx   = CW'(i);
                writeBurst = entBurst[i];
            end
        end
    end

endmodule : tenure_queue
